// [common/dopp_pkg.sv]
/*
 Shared constants for the digital output pattern port: pattern width, reset
 pattern, command kinds, character codes of the text parameter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dopp_pkg;
   localparam int         PAT_W       = 4;
   localparam logic [3:0] PAT_RESET   = 4'hf;
   localparam logic [3:0] PAT_MAX     = 4'hf;
   localparam int         ACC_W       = 8;
   localparam logic [7:0] DEC_LIMIT   = 8'h0f;
   localparam logic [7:0] CH_HASH     = 8'h23;
   localparam logic [7:0] CH_0        = 8'h30;
   localparam logic [7:0] CH_1        = 8'h31;
   localparam logic [7:0] CH_7        = 8'h37;
   localparam logic [7:0] CH_9        = 8'h39;
   localparam logic [7:0] CH_UA       = 8'h41;
   localparam logic [7:0] CH_UF       = 8'h46;
   localparam logic [7:0] CH_LA       = 8'h61;
   localparam logic [7:0] CH_LF       = 8'h66;
   localparam logic [7:0] CH_B        = 8'h42;
   localparam logic [7:0] CH_H        = 8'h48;
   localparam logic [7:0] CH_Q        = 8'h51;
   localparam logic [7:0] CASE_BIT    = 8'h20;
   localparam int         BIN_DIGITS  = 4;
   localparam int         HEX_DIGITS  = 1;
   localparam int         OCT_DIGITS  = 2;
   localparam int         DEC_DIGITS  = 3;
   localparam logic [7:0] TEN         = 8'h0a;
   // Parser states, one-hot
   typedef enum logic [4:0] {
      DOPP_IDLE = 5'h01,
      DOPP_DEC  = 5'h02,
      DOPP_HDR  = 5'h04,
      DOPP_NDN  = 5'h08,
      DOPP_BAD  = 5'h10
   } dopp_state_t;
   // Radix of a non-decimal parameter
   typedef enum logic [1:0] {
      DOPP_RAD_BIN = 2'h0,
      DOPP_RAD_HEX = 2'h1,
      DOPP_RAD_OCT = 2'h2
   } dopp_radix_t;
endpackage

// [rtl/dopp_line_drv.sv]
/*
 One open-collector output line of the pattern port.
 Assumes the pattern bit arrives from a flip-flop on the same clock.
*/
`timescale 1ns/1ns
module dopp_line_drv
   import dopp_pkg::*;
(
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   input  wire logic i_ce,
   input  wire logic i_bit,
   output logic      o_sink
);
   // Set bit = HI = transistor off; clear bit = LO = transistor sinks to 0V
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sink <= 1'b0;
      end else if (i_ce) begin
         o_sink <= ~i_bit;
      end
   end
endmodule

// [rtl/dopp_port.sv]
/*
 Digital output pattern port: holds the 4-bit pattern, parses the text
 parameter of the output_pattern_command (decimal, #B, #H, #Q), answers the
 query in decimal, and serves the front-panel edit path.
 Assumes command characters and panel strobes come from logic on i_ref_clk;
 the four o_line_* outputs drive open-collector transistors with pull-ups.
*/
// How it works
// - One 4-bit pattern value, 0 to 15, drives the four output lines bit for bit.
// - Weight 8 drives line four, 4 line three, 2 line two, 1 line one; a set bit makes the line HI.
// - Reset loads pattern 15 so that all lines are HI.
// - A query returns the held pattern as decimal characters whatever form wrote it.
// - The write accepts #B and four binary digits, most significant line first.
// - The write accepts #H and one hex digit 0 to F.
// - The write accepts #Q and exactly two octal digits, 00 to 17.
// - The panel menu shows the present value on entry and loads an edited value 0 to 15 on confirm unless a text write is accepted in the same cycle.
// - A LO line turns its output transistor on to pull to 0V; a HI line turns it off.
`timescale 1ns/1ns
module dopp_port
   import dopp_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_ce,
   input  wire logic       i_cmd_valid,
   input  wire logic [7:0] i_cmd_char,
   input  wire logic       i_cmd_end,
   input  wire logic       i_query,
   input  wire logic       i_menu_enter,
   input  wire logic       i_menu_confirm,
   input  wire logic [4:0] i_menu_value,
   output logic [3:0]      o_line_sink,
   output logic [3:0]      o_pattern,
   output logic            o_menu_show,
   output logic [3:0]      o_menu_value,
   output logic            o_resp_valid,
   output logic [7:0]      o_resp_tens,
   output logic [7:0]      o_resp_ones,
   output logic            o_cmd_done,
   output logic            o_cmd_reject
);
   logic        rst_s1_r;
   logic        rst_b_r;
   dopp_state_t state_r;
   dopp_state_t state_nxt;
   dopp_radix_t radix_r;
   logic [7:0]  acc_r;
   logic [7:0]  acc_nxt;
   logic [2:0]  ndig_r;
   logic [3:0]  pattern_r;
   logic [7:0]  up_ch;
   logic        is_dec;
   logic        dig_ok;
   logic [3:0]  dig_val;
   logic [2:0]  need;
   logic        fin_ok;
   logic        cmd_fin;

   // Reset release through two flip-flops
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_r <= 1'b0;
         rst_b_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_b_r  <= rst_s1_r;
      end
   end

   // Character classification
   always_comb begin
      up_ch   = i_cmd_char & ~CASE_BIT;
      is_dec  = (i_cmd_char >= CH_0) && (i_cmd_char <= CH_9);
      dig_ok  = 1'b0;
      dig_val = 4'h0;
      unique case (radix_r)
         DOPP_RAD_BIN: begin
            dig_ok  = (i_cmd_char == CH_0) || (i_cmd_char == CH_1);
            dig_val = i_cmd_char[3:0];
         end
         DOPP_RAD_HEX: begin
            if (is_dec) begin
               dig_ok  = 1'b1;
               dig_val = i_cmd_char[3:0];
            end else if (up_ch >= CH_UA && up_ch <= CH_UF) begin
               dig_ok  = 1'b1;
               dig_val = 4'(up_ch - CH_UA + TEN);
            end
         end
         DOPP_RAD_OCT: begin
            dig_ok  = (i_cmd_char >= CH_0) && (i_cmd_char <= CH_7);
            dig_val = i_cmd_char[3:0];
         end
         default: begin
            dig_ok  = 1'b0;
            dig_val = 4'h0;
         end
      endcase
      unique case (radix_r)
         DOPP_RAD_BIN: need = 3'(BIN_DIGITS);
         DOPP_RAD_HEX: need = 3'(HEX_DIGITS);
         default:      need = 3'(OCT_DIGITS);
      endcase
   end

   // Parser state and accumulator
   always_comb begin
      state_nxt = state_r;
      acc_nxt   = acc_r;
      if (i_cmd_valid) begin
         unique case (state_r)
            DOPP_IDLE: begin
               acc_nxt = 8'h00;
               if (i_cmd_char == CH_HASH) begin
                  state_nxt = DOPP_HDR;
               end else if (is_dec) begin
                  state_nxt = DOPP_DEC;
                  acc_nxt   = 8'(i_cmd_char - CH_0);
               end else begin
                  state_nxt = DOPP_BAD;
               end
            end
            DOPP_DEC: begin
               if (is_dec && ndig_r < 3'(DEC_DIGITS)) begin
                  // Hold a value already above 15 so a third digit cannot wrap it back into range
                  acc_nxt = (acc_r > DEC_LIMIT) ? acc_r : 8'(acc_r * TEN + (i_cmd_char - CH_0));
               end else begin
                  state_nxt = DOPP_BAD;
               end
            end
            DOPP_HDR: begin
               if (up_ch == CH_B || up_ch == CH_H || up_ch == CH_Q) begin
                  state_nxt = DOPP_NDN;
               end else begin
                  state_nxt = DOPP_BAD;
               end
            end
            DOPP_NDN: begin
               if (dig_ok && ndig_r < need) begin
                  acc_nxt = (radix_r == DOPP_RAD_BIN) ? {acc_r[6:0], 1'b0} | 8'(dig_val) :
                            (radix_r == DOPP_RAD_OCT) ? {acc_r[4:0], 3'h0} | 8'(dig_val) :
                                                        8'(dig_val);
               end else begin
                  state_nxt = DOPP_BAD;
               end
            end
            DOPP_BAD: state_nxt = DOPP_BAD;
         endcase
      end
   end

   // A finished write is legal only with a value in range and, for #B, #H and #Q, the exact digit count
   assign cmd_fin = i_cmd_end && state_r != DOPP_IDLE;
   assign fin_ok  = ((state_r == DOPP_DEC) && acc_r <= DEC_LIMIT)
                 || ((state_r == DOPP_NDN) && ndig_r == need && acc_r <= DEC_LIMIT);

   always_ff @(posedge i_ref_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         state_r <= DOPP_IDLE;
         acc_r   <= 8'h00;
         ndig_r  <= 3'h0;
         radix_r <= DOPP_RAD_BIN;
      end else if (i_ce) begin
         if (i_cmd_end) begin
            state_r <= DOPP_IDLE;
            acc_r   <= 8'h00;
            ndig_r  <= 3'h0;
         end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            if (i_cmd_valid) begin
               if (state_r == DOPP_IDLE || state_r == DOPP_HDR) begin
                  ndig_r <= (state_r == DOPP_IDLE && is_dec) ? 3'h1 : 3'h0;
               end else if (ndig_r != 3'h7) begin
                  ndig_r <= ndig_r + 3'h1;
               end
               if (state_r == DOPP_HDR) begin
                  radix_r <= (up_ch == CH_B) ? DOPP_RAD_BIN :
                             (up_ch == CH_H) ? DOPP_RAD_HEX : DOPP_RAD_OCT;
               end
            end
         end
      end
   end

   // Held pattern: reset to 15, written by text command or panel confirm
   always_ff @(posedge i_ref_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         pattern_r <= PAT_RESET;
      end else if (i_ce) begin
         if (cmd_fin && fin_ok) begin
            pattern_r <= acc_r[3:0];
         end else if (i_menu_confirm && i_menu_value <= 5'(PAT_MAX)) begin
            pattern_r <= i_menu_value[3:0];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         o_cmd_done   <= 1'b0;
         o_cmd_reject <= 1'b0;
         o_pattern    <= PAT_RESET;
      end else if (i_ce) begin
         o_cmd_done   <= cmd_fin && fin_ok;
         o_cmd_reject <= cmd_fin && !fin_ok;
         o_pattern    <= pattern_r;
      end
   end

   // Query answer as two ASCII decimal digits
   always_ff @(posedge i_ref_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         o_resp_valid <= 1'b0;
         o_resp_tens  <= CH_0;
         o_resp_ones  <= CH_0;
      end else if (i_ce) begin
         o_resp_valid <= i_query;
         if (i_query) begin
            o_resp_tens <= (pattern_r >= 4'(TEN)) ? CH_1 : CH_0;
            o_resp_ones <= CH_0 + 8'((pattern_r >= 4'(TEN)) ? pattern_r - 4'(TEN) : pattern_r);
         end
      end
   end

   // Panel menu shows the present value on entry
   always_ff @(posedge i_ref_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         o_menu_show  <= 1'b0;
         o_menu_value <= PAT_RESET;
      end else if (i_ce) begin
         if (i_menu_enter) begin
            o_menu_show  <= 1'b1;
            o_menu_value <= pattern_r;
         end else if (i_menu_confirm) begin
            o_menu_show  <= 1'b0;
         end
      end
   end

   // Bit weight 1 on line one up to weight 8 on line four
   for (genvar g = 0; g < PAT_W; g++) begin : g_line
      dopp_line_drv u_drv (
         .i_ref_clk (i_ref_clk),
         .i_rst_b   (rst_b_r),
         .i_ce      (i_ce),
         .i_bit     (pattern_r[g]),
         .o_sink    (o_line_sink[g])
      );
   end
endmodule

// [verification/dopp_port_chk.sv]
/* Concurrent checks on the pattern port outputs.
 Assumes panel and command traffic never overlap. */
`timescale 1ns/1ns
module dopp_port_chk
   import dopp_pkg::*;
(
   input wire logic       i_ref_clk,
   input wire logic       i_rst_b,
   input wire logic       i_ce,
   input wire logic       i_cmd_valid,
   input wire logic [7:0] i_cmd_char,
   input wire logic       i_cmd_end,
   input wire logic       i_query,
   input wire logic       i_menu_enter,
   input wire logic       i_menu_confirm,
   input wire logic [4:0] i_menu_value,
   input wire logic [3:0] o_line_sink,
   input wire logic [3:0] o_pattern,
   input wire logic       o_menu_show,
   input wire logic [3:0] o_menu_value,
   input wire logic       o_resp_valid,
   input wire logic [7:0] o_resp_tens,
   input wire logic [7:0] o_resp_ones,
   input wire logic       o_cmd_done,
   input wire logic       o_cmd_reject
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   property p_line_inv; o_line_sink == ~o_pattern; endproperty
   a_line_inv: assert property (p_line_inv)
      else $error("line sink is not the inverse of the pattern");
   property p_rst_val; $rose(i_rst_b) |-> o_pattern == PAT_RESET; endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("pattern not 15 at reset release");
   property p_rej_hold; o_cmd_reject |=> $stable(o_pattern) && $stable(o_line_sink); endproperty
   a_rej_hold: assert property (p_rej_hold)
      else $error("rejected write changed the pattern");
   property p_resp_val;
      o_resp_valid |-> o_resp_tens == (o_pattern > 4'h9 ? 8'h31 : 8'h30)
         && o_resp_ones == 8'h30 + {4'h0, o_pattern} - (o_pattern > 4'h9 ? 8'h0a : 8'h00);
   endproperty
   a_resp_val: assert property (p_resp_val)
      else $error("query answer is not the decimal pattern");
   property p_resp_time; i_query && i_ce |=> o_resp_valid; endproperty
   a_resp_time: assert property (p_resp_time)
      else $error("query not answered next cycle");
   property p_cmd_cause; o_cmd_done || o_cmd_reject |-> $past(i_cmd_end && i_ce); endproperty
   a_cmd_cause: assert property (p_cmd_cause)
      else $error("write verdict without end of parameter");
   property p_cmd_excl; !(o_cmd_done && o_cmd_reject); endproperty
   a_cmd_excl: assert property (p_cmd_excl)
      else $error("write both accepted and rejected");
   property p_menu; i_menu_enter && i_ce |=> o_menu_show && o_menu_value == o_pattern; endproperty
   a_menu: assert property (p_menu)
      else $error("menu entry does not show the present pattern");
endmodule
bind dopp_port dopp_port_chk u_chk (
   .i_ref_clk      (i_ref_clk),
   .i_rst_b        (i_rst_b),
   .i_ce           (i_ce),
   .i_cmd_valid    (i_cmd_valid),
   .i_cmd_char     (i_cmd_char),
   .i_cmd_end      (i_cmd_end),
   .i_query        (i_query),
   .i_menu_enter   (i_menu_enter),
   .i_menu_confirm (i_menu_confirm),
   .i_menu_value   (i_menu_value),
   .o_line_sink    (o_line_sink),
   .o_pattern      (o_pattern),
   .o_menu_show    (o_menu_show),
   .o_menu_value   (o_menu_value),
   .o_resp_valid   (o_resp_valid),
   .o_resp_tens    (o_resp_tens),
   .o_resp_ones    (o_resp_ones),
   .o_cmd_done     (o_cmd_done),
   .o_cmd_reject   (o_cmd_reject)
);

// [verification/dopp_line_load.sv]
/* External logic load on the four open-collector lines.
 Assumes a pull-up on every line. */
`timescale 1ns/1ns
module dopp_line_load (
   input  wire logic [3:0] i_line_sink,
   output logic      [3:0] o_line_level
);
   // Pull-up holds a line HI unless its transistor sinks it to 0V
   assign o_line_level = ~i_line_sink;
endmodule

// [verification/dopp_port_tb.sv]
/* Self-checking bench of the pattern port.
 Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module dopp_port_tb
   import dopp_pkg::*;
;
   logic       i_ref_clk = 0, i_rst_b = 0, i_ce = 1, i_cmd_valid = 0, i_cmd_end = 0;
   logic       i_query = 0, i_menu_enter = 0, i_menu_confirm = 0;
   logic [7:0] i_cmd_char = 8'h00;
   logic [4:0] i_menu_value = 5'h00;
   logic [3:0] o_line_sink, o_pattern, o_menu_value, line_lvl;
   logic       o_menu_show, o_resp_valid, o_cmd_done, o_cmd_reject;
   logic [7:0] o_resp_tens, o_resp_ones;
   int         fails = 0, check_count = 0, cyc = 0;
   dopp_port u_dut (
      .i_ref_clk      (i_ref_clk),
      .i_rst_b        (i_rst_b),
      .i_ce           (i_ce),
      .i_cmd_valid    (i_cmd_valid),
      .i_cmd_char     (i_cmd_char),
      .i_cmd_end      (i_cmd_end),
      .i_query        (i_query),
      .i_menu_enter   (i_menu_enter),
      .i_menu_confirm (i_menu_confirm),
      .i_menu_value   (i_menu_value),
      .o_line_sink    (o_line_sink),
      .o_pattern      (o_pattern),
      .o_menu_show    (o_menu_show),
      .o_menu_value   (o_menu_value),
      .o_resp_valid   (o_resp_valid),
      .o_resp_tens    (o_resp_tens),
      .o_resp_ones    (o_resp_ones),
      .o_cmd_done     (o_cmd_done),
      .o_cmd_reject   (o_cmd_reject)
   );
   dopp_line_load u_load (.i_line_sink(o_line_sink), .o_line_level(line_lvl));
   always #10 i_ref_clk = ~i_ref_clk;
   task stop_test;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         stop_test();
      end
   end
   task automatic send(input string s);
      for (int k = 0; k < s.len(); k++) begin
         @(posedge i_ref_clk);
         i_cmd_valid <= 1'b1;
         i_cmd_char  <= s[k];
      end
      @(posedge i_ref_clk);
      i_cmd_valid <= 1'b0;
      i_cmd_end   <= 1'b1;
      @(posedge i_ref_clk);
      i_cmd_end <= 1'b0;
   endtask
   task automatic wr(input string s, input logic ok, input logic [3:0] exp);
      send(s);
      #1;
      `CHK(o_cmd_done, ok)
      `CHK(o_cmd_reject, ~ok)
      @(posedge i_ref_clk);
      #1;
      `CHK(o_pattern, exp)
      `CHK(line_lvl, exp)
   endtask
   task automatic qry(input logic [7:0] t, input logic [7:0] o);
      @(posedge i_ref_clk);
      i_query <= 1'b1;
      @(posedge i_ref_clk);
      i_query <= 1'b0;
      #1;
      `CHK(o_resp_valid, 1'b1)
      `CHK({o_resp_tens, o_resp_ones}, {t, o})
   endtask
   task automatic menu(input logic [4:0] v, input logic [3:0] shown, input logic [3:0] exp);
      @(posedge i_ref_clk);
      i_menu_enter <= 1'b1;
      @(posedge i_ref_clk);
      i_menu_enter <= 1'b0;
      #1;
      `CHK({o_menu_show, o_menu_value}, {1'b1, shown})
      @(posedge i_ref_clk);
      i_menu_confirm <= 1'b1;
      i_menu_value   <= v;
      @(posedge i_ref_clk);
      i_menu_confirm <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK(o_pattern, exp)
      `CHK(o_menu_show, 1'b0)
   endtask
   task t_reset;
      #1;
      `CHK(o_pattern, PAT_RESET)
      `CHK(line_lvl, 4'hf)
      qry(8'h31, 8'h35);
      $display("test reset done");
   endtask
   task t_forms;
      wr("10", 1'b1, 4'ha);
      qry(8'h31, 8'h30);
      wr("007", 1'b1, 4'h7);
      wr("#B0101", 1'b1, 4'h5);
      wr("#hc", 1'b1, 4'hc);
      wr("#H0", 1'b1, 4'h0);
      wr("#Q17", 1'b1, 4'hf);
      wr("#q05", 1'b1, 4'h5);
      qry(8'h30, 8'h35);
      $display("test forms done");
   endtask
   task t_reject;
      wr("16", 1'b0, 4'h5);
      wr("#B102", 1'b0, 4'h5);
      wr("#Q18", 1'b0, 4'h5);
      wr("#HG", 1'b0, 4'h5);
      wr("256", 1'b0, 4'h5);
      wr("#Q7", 1'b0, 4'h5);
      wr("#B101", 1'b0, 4'h5);
      wr("#H1f", 1'b0, 4'h5);
      $display("test reject done");
   endtask
   task t_menu;
      menu(5'h03, 4'h5, 4'h3);
      menu(5'h14, 4'h3, 4'h3);
      $display("test menu done");
   endtask
   task t_hold;
      @(posedge i_ref_clk);
      i_ce <= 1'b0;
      send("#H9");
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK({o_cmd_done, o_cmd_reject}, 2'b00)
      `CHK(o_pattern, 4'h5)
      @(posedge i_ref_clk);
      i_ce <= 1'b1;
      qry(8'h30, 8'h35);
      $display("test hold done");
   endtask
   task t_rerst;
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      `CHK(o_pattern, PAT_RESET)
      `CHK(line_lvl, 4'hf)
      qry(8'h31, 8'h35);
      $display("test second reset done");
   endtask
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      t_reset();
      t_forms();
      t_reject();
      t_hold();
      t_menu();
      t_rerst();
      stop_test();
   end
endmodule
